// *** wdtb_pkg.sv ***
// Purpose: constants, carrier types and the oscillator edge detector of the watchdog block
// Assumes: one 20 MHz clock; low_freq_osc arrives from another clock domain
// Notes:   register offsets are byte addresses on the Avalon-MM slave
//
// Summary of operation
// - mode 01 runs the watchdog while sw_wdt_enable is 1, stops it at 0.
// - in mode 01 sleep does not change the enabled state.
// - mode 00 keeps the watchdog off and ignores sw_wdt_enable.
// - any reset loads period_select 01011 (1:65536, ~2 s) and clears sw_wdt_enable.
// - period code n up to 10010 gives prescale 32 * 2^n.
// - codes 10011 to 11111 act as the shortest period, 1:32.
// - counting is timed by low_freq_osc at about 31 kHz.
// - reset, clear instruction and oscillator failure clear the count.
// - sleep entry and sleep exit each clear the count.
// - count is held at zero whenever the watchdog is disabled.
// - internal oscillator divider changes never touch the count.
// - when enabled in sleep, counting restarts from zero after the entry clear.
// - time-out in sleep wakes the device, no reset, and updates both status flags.
// - a watchdog reset clears the active-low reset flag in power control.
// - bits 7 and 6 of watchdog_control read as zero.
// - time-out while awake and enabled requests a device reset.
// - mode 11 keeps the watchdog on always, sleep included.
// - mode 10 runs the watchdog awake and stops it in sleep.

`timescale 1ns/1ps
`default_nettype none

package wdtb_pkg;

	//----------------------------------------
	// register map
	//----------------------------------------
	localparam logic [3:0] CTRL_OFFSET    = 4'h0;
	localparam logic [3:0] POWER_CONTROL_REG_OFFSET    = 4'h4;
	localparam logic [3:0] STAT_OFFSET    = 4'h8;
	localparam int         CTRL_EN_BIT    = 0;
	localparam int         CTRL_PS_LSB    = 1;
	localparam int         POWER_CONTROL_REG_WDT_RESET_FLAG_N_BIT  = 4;
	localparam int         STAT_ACT_BIT   = 0;
	localparam int         STAT_SLP_BIT   = 1;
	localparam int         STAT_PD_BIT    = 3;
	localparam int         STAT_TO_BIT    = 4;

	//----------------------------------------
	// reset values and period decode
	//----------------------------------------
	localparam logic [4:0] PERIOD_RESET    = 5'h0b;
	localparam logic       SW_EN_RESET     = 1'b0;
	localparam logic [4:0] PERIOD_MAX_CODE = 5'h12;
	localparam logic [4:0] PS_MIN_LOG2     = 5'h05;
	localparam int         CNT_WIDTH       = 23;
	localparam int         LFO_FREQ_HZ     = 31000;

	//----------------------------------------
	// configuration mode codes
	//----------------------------------------
	localparam logic [1:0] MODE_OFF      = 2'h0;
	localparam logic [1:0] MODE_SOFTWARE = 2'h1;
	localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
	localparam logic [1:0] MODE_ALWAYS   = 2'h3;

	typedef struct packed {
		logic sys_reset;
		logic clear_instr;
		logic sleep_enter;
		logic sleep_exit;
		logic osc_fail;
	} wdtb_core_evt_type;

endpackage : wdtb_pkg

// two-stage synchroniser and rising-edge tick for the low-frequency oscillator
module wdtb_lfo_edge (
	input  wire logic ref_clk,   // system clock
	input  wire logic reset_n,   // synchronous reset, active low
	input  wire logic ce,        // clock enable
	input  wire logic osc_in,    // asynchronous oscillator pin
	output logic      tick       // one-cycle pulse per rising edge
);
	logic meta;
	logic sync;
	logic last;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
			tick <= 1'b0;
		end else if (ce) begin
			meta <= osc_in;
			sync <= meta;
			last <= sync;
			tick <= sync & ~last;
		end
	end
endmodule : wdtb_lfo_edge

`default_nettype wire

// *** wdtb_watchdog.sv ***
// Purpose: watchdog timer with sleep wake-up and an Avalon-MM register slave
// Assumes: core events are same-clock one-cycle pulses; wdt_mode_cfg is static
// Notes:   reset_n is power-on; core_evt.sys_reset is any later device reset
//
// Chosen here: register access over Avalon-MM and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module wdtb_watchdog #(
	parameter int CNT_W = wdtb_pkg::CNT_WIDTH   // prescaler width
) (
	input  wire logic                       ref_clk,            // 20 MHz clock
	input  wire logic                       reset_n,            // sync reset, low
	input  wire logic                       ce,                 // clock enable
	input  wire logic                       low_freq_osc,       // 31 kHz pin
	input  wire logic [1:0]                 wdt_mode_cfg,       // config mode
	input  wire wdtb_pkg::wdtb_core_evt_type core_evt,          // core pulses
	input  wire logic [3:0]                 avs_address,        // byte address
	input  wire logic                       avs_read,           // read strobe
	input  wire logic                       avs_write,          // write strobe
	input  wire logic [3:0]                 avs_byteenable,     // byte lanes
	input  wire logic [31:0]                avs_writedata,      // write data
	output logic [31:0]                     avs_readdata,       // read data
	output logic                            avs_waitrequest,    // stall
	output logic                            wdt_reset_req,      // reset pulse
	output logic                            wake_req,           // wake pulse
	output logic                            timeout_flag_n,     // time-out, low
	output logic                            powerdown_flag_n,   // power-down, low
	output logic                            wdt_reset_flag_n    // wdt reset, low
);
	import wdtb_pkg::*;

	typedef enum logic {PWR_AWAKE, PWR_ASLEEP} wdtb_pwr_type;

	wdtb_pwr_type     pwr;
	logic [4:0]       period_select;
	logic             sw_wdt_enable;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] mask;
	logic             lfo_tick;
	logic             active;
	logic             clr_now;
	logic             tmo;
	logic             acc;
	logic             wr_ctrl;
	logic             wr_power_control_reg;
	logic [31:0]      next_readdata;

	//----------------------------------------
	// oscillator edge
	//----------------------------------------
	wdtb_lfo_edge u_lfo (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.ce      (ce),
		.osc_in  (low_freq_osc),
		.tick    (lfo_tick)
	);

	//----------------------------------------
	// period decode
	//----------------------------------------
	function automatic logic [CNT_W-1:0] period_mask(input logic [4:0] sel);
		logic [4:0] k;
		logic [CNT_W-1:0] m;
		k = (sel > PERIOD_MAX_CODE) ? PS_MIN_LOG2 : 5'(sel + PS_MIN_LOG2);
		m = '0;
		for (int i = 0; i < CNT_W; i++) begin
			m[i] = (i < int'(k));
		end
		return m;
	endfunction : period_mask

	assign mask = period_mask(period_select);

	//----------------------------------------
	// enable decode
	//----------------------------------------
	always_comb begin
		unique case (wdt_mode_cfg)
			MODE_ALWAYS:   active = 1'b1;
			MODE_NO_SLEEP: active = (pwr == PWR_AWAKE);
			MODE_SOFTWARE: active = sw_wdt_enable;
			MODE_OFF:      active = 1'b0;
		endcase
	end

	// divider selection of the fast oscillator is not an input: nothing else clears
	assign clr_now = core_evt.sys_reset | core_evt.clear_instr | core_evt.osc_fail
		| core_evt.sleep_enter | core_evt.sleep_exit | ~active;
	assign tmo = active & lfo_tick & ~clr_now & ((count & mask) == mask);

	//----------------------------------------
	// prescaler counter
	//----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			count <= '0;
		end else if (ce) begin
			if (clr_now || tmo) begin
				count <= '0;
			end else if (lfo_tick) begin
				count <= count + 1'b1;
			end
		end
	end

	//----------------------------------------
	// sleep state
	//----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pwr <= PWR_AWAKE;
		end else if (ce) begin
			unique case (pwr)
				PWR_AWAKE: begin
					if (core_evt.sleep_enter && !core_evt.sys_reset) begin
						pwr <= PWR_ASLEEP;
					end
				end
				PWR_ASLEEP: begin
					if (core_evt.sleep_exit || core_evt.sys_reset || tmo) begin
						pwr <= PWR_AWAKE;
					end
				end
			endcase
		end
	end

	//----------------------------------------
	// time-out outputs
	//----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wdt_reset_req <= 1'b0;
			wake_req      <= 1'b0;
		end else if (ce) begin
			wdt_reset_req <= tmo && (pwr == PWR_AWAKE);
			wake_req      <= tmo && (pwr == PWR_ASLEEP);
		end
	end

	//----------------------------------------
	// status flags
	//----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end else if (ce) begin
			if (tmo) begin
				timeout_flag_n <= 1'b0;
			end else if (core_evt.clear_instr || core_evt.sleep_enter) begin
				timeout_flag_n <= 1'b1;
			end
			if (core_evt.sleep_enter || (tmo && pwr == PWR_ASLEEP)) begin
				powerdown_flag_n <= 1'b0;
			end else if (core_evt.clear_instr) begin
				powerdown_flag_n <= 1'b1;
			end
		end
	end

	// hardware clear wins over a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			wdt_reset_flag_n <= 1'b1;
		end else if (ce) begin
			if (tmo && pwr == PWR_AWAKE) begin
				wdt_reset_flag_n <= 1'b0;
			end else if (wr_power_control_reg) begin
				wdt_reset_flag_n <= avs_writedata[POWER_CONTROL_REG_WDT_RESET_FLAG_N_BIT];
			end
		end
	end

	//----------------------------------------
	// Avalon-MM slave
	//----------------------------------------
	assign acc     = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_ctrl = acc & avs_write & avs_byteenable[0] & (avs_address == CTRL_OFFSET);
	assign wr_power_control_reg = acc & avs_write & avs_byteenable[0] & (avs_address == POWER_CONTROL_REG_OFFSET);

	// one wait state per access; the request completes on the second edge
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
		end else if (ce) begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			period_select <= PERIOD_RESET;
			sw_wdt_enable <= SW_EN_RESET;
		end else if (ce) begin
			if (core_evt.sys_reset) begin
				period_select <= PERIOD_RESET;
				sw_wdt_enable <= SW_EN_RESET;
			end else if (wr_ctrl) begin
				period_select <= avs_writedata[CTRL_PS_LSB +: 5];
				sw_wdt_enable <= avs_writedata[CTRL_EN_BIT];
			end
		end
	end

	always_comb begin
		next_readdata = '0;
		unique case (avs_address)
			CTRL_OFFSET: begin
				next_readdata[CTRL_PS_LSB +: 5] = period_select;
				next_readdata[CTRL_EN_BIT]      = sw_wdt_enable;
			end
			POWER_CONTROL_REG_OFFSET: begin
				next_readdata[POWER_CONTROL_REG_WDT_RESET_FLAG_N_BIT] = wdt_reset_flag_n;
			end
			STAT_OFFSET: begin
				next_readdata[STAT_TO_BIT]  = timeout_flag_n;
				next_readdata[STAT_PD_BIT]  = powerdown_flag_n;
				next_readdata[STAT_SLP_BIT] = (pwr == PWR_ASLEEP);
				next_readdata[STAT_ACT_BIT] = active;
			end
			default: next_readdata = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			avs_readdata <= '0;
		end else if (ce) begin
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	//----------------------------------------
	// reference tick count for the period checks
	//----------------------------------------
	localparam int TICK_W = CNT_W + 1;

	logic [TICK_W-1:0] chk_ticks;    // ticks since the last clear
	logic [TICK_W-1:0] chk_period;   // ticks in the selected period
	logic              chk_valid;    // no period write since the last clear

	// counted in ticks rather than masked, so a wrong decode shows up
	assign chk_period = TICK_W'(1) << (PS_MIN_LOG2
		+ ((period_select > PERIOD_MAX_CODE) ? 5'h00 : period_select));

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			chk_ticks <= '0;
			chk_valid <= 1'b1;
		end else if (ce) begin
			if (clr_now || tmo) begin
				chk_ticks <= '0;
				chk_valid <= 1'b1;
			end else begin
				if (lfo_tick) begin
					chk_ticks <= chk_ticks + 1'b1;
				end
				if (wr_ctrl) begin
					chk_valid <= 1'b0;
				end
			end
		end
	end

	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_sleep_tmo;
		ce && tmo && pwr == PWR_ASLEEP;
	endsequence

	sequence s_wake_seen;
		wake_req && !wdt_reset_req && !timeout_flag_n && !powerdown_flag_n;
	endsequence

	sequence s_bus_req;
		ce && (avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence s_bus_done;
		!avs_waitrequest;
	endsequence

	a_off_mode_idle: assert property (wdt_mode_cfg == MODE_OFF |-> !active && !tmo)
		else $error("watchdog active in off mode");
	a_sw_mode_follow: assert property (wdt_mode_cfg == MODE_SOFTWARE
		|-> active == sw_wdt_enable)
		else $error("software mode does not follow enable bit");
	a_always_on_mode: assert property (wdt_mode_cfg == MODE_ALWAYS |-> active)
		else $error("always-on mode found disabled");
	a_no_sleep_mode: assert property (wdt_mode_cfg == MODE_NO_SLEEP
		|-> active == (pwr == PWR_AWAKE))
		else $error("off-in-sleep mode wrong");
	a_reset_values: assert property (ce && core_evt.sys_reset
		|=> period_select == PERIOD_RESET && sw_wdt_enable == SW_EN_RESET)
		else $error("reset values not loaded");
	a_clear_count: assert property (ce && (core_evt.clear_instr || core_evt.osc_fail)
		|=> count == '0)
		else $error("count not cleared");
	a_sleep_edges: assert property (ce && (core_evt.sleep_enter || core_evt.sleep_exit)
		|=> count == '0)
		else $error("count not cleared at sleep edge");
	a_disabled_held: assert property (ce && !active |=> count == '0)
		else $error("count moved while disabled");
	a_reserved_min: assert property (period_select > PERIOD_MAX_CODE
		|-> mask == CNT_W'(32'h1f))
		else $error("reserved code not minimum period");
	a_awake_reset: assert property (ce && tmo && pwr == PWR_AWAKE
		|=> wdt_reset_req && !wake_req && !wdt_reset_flag_n)
		else $error("awake time-out gave no reset");
	a_sleep_wake: assert property (s_sleep_tmo |=> s_wake_seen ##0 pwr == PWR_AWAKE)
		else $error("sleep time-out did not wake");
	a_ctrl_top_zero: assert property (ce && avs_read && avs_waitrequest
		&& avs_address == CTRL_OFFSET |=> avs_readdata[31:6] == '0)
		else $error("control upper bits not zero");
	a_bus_one_wait: assert property (s_bus_req |=> s_bus_done)
		else $error("access not answered after one wait cycle");
	a_bus_release: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_count_step: assert property (ce && lfo_tick && !clr_now && !tmo
		|=> count == $past(count) + 1'b1)
		else $error("count did not step on tick");
	a_count_hold: assert property (ce && !lfo_tick && !clr_now |=> $stable(count))
		else $error("count moved without tick or clear");
	a_ce_freeze: assert property (!ce |=> $stable(count) && $stable(pwr)
		&& $stable(period_select) && $stable(timeout_flag_n))
		else $error("state moved while clock enable low");
	a_sleep_flags: assert property (ce && core_evt.sleep_enter
		|=> timeout_flag_n && !powerdown_flag_n)
		else $error("flags wrong after sleep entry");
	a_clear_flags: assert property (ce && core_evt.clear_instr && !core_evt.sleep_enter
		|=> timeout_flag_n && powerdown_flag_n)
		else $error("flags wrong after clear instruction");
	a_sys_reset_state: assert property (ce && core_evt.sys_reset
		|=> pwr == PWR_AWAKE && count == '0)
		else $error("device reset left state behind");
	a_wdt_reset_flag_n_hold: assert property (ce && !(tmo && pwr == PWR_AWAKE) && !wr_power_control_reg
		|=> $stable(wdt_reset_flag_n))
		else $error("reset flag changed without cause");
	a_ctrl_write: assert property (ce && wr_ctrl && !core_evt.sys_reset
		|=> period_select == $past(avs_writedata[CTRL_PS_LSB +: 5])
		&& sw_wdt_enable == $past(avs_writedata[CTRL_EN_BIT]))
		else $error("control write not stored");
	a_idle_no_pulse: assert property (ce && !lfo_tick |=> !wdt_reset_req && !wake_req)
		else $error("time-out pulse without tick");
	a_tick_period: assert property (ce && chk_valid && tmo
		|-> chk_ticks == chk_period - 1'b1)
		else $error("time-out at wrong tick count");
	a_tick_bound: assert property (chk_valid |-> chk_ticks < chk_period)
		else $error("tick count passed the period");
	a_tmo_due: assert property (ce && chk_valid && active && lfo_tick && !clr_now
		&& chk_ticks == chk_period - 1'b1 |-> tmo)
		else $error("time-out missed at end of period");

endmodule : wdtb_watchdog

`default_nettype wire

// *** wdtb_core_model.sv ***
// Purpose: processor-core stand-in that sends watchdog events and runs the slow oscillator
// Assumes: events are one-cycle pulses on ref_clk
// Notes:   oscillator is sped up to an 8-cycle period to keep runs short

`timescale 1ns/1ps
`default_nettype none

module wdtb_core_model (
	input  wire logic                        ref_clk,      // system clock
	output var  wdtb_pkg::wdtb_core_evt_type core_evt,     // event pulses
	output logic                             low_freq_osc  // free-running oscillator
);
	import wdtb_pkg::*;

	initial begin
		core_evt = '0;
	end

	// oscillator runs free, also outside any operation
	initial begin
		low_freq_osc = 1'b0;
		forever begin
			repeat (4) @(posedge ref_clk);
			low_freq_osc <= ~low_freq_osc;
		end
	end

	// one event bit high for exactly one cycle
	task automatic send(input int idx);
		@(posedge ref_clk);
		core_evt[idx] <= 1'b1;
		@(posedge ref_clk);
		core_evt <= '0;
	endtask : send
endmodule : wdtb_core_model

`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the watchdog block
// Assumes: oscillator tick every 8 cycles, so a period of 2^k ticks is 8<<k cycles
// Notes:   event bits: 4 sys_reset, 3 clear, 2 sleep enter, 1 sleep exit, 0 osc fail

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import wdtb_pkg::*;
	logic              ref_clk = 1'b0;
	logic              reset_n = 1'b0;
	logic [1:0]        mode    = 2'h1;
	logic [3:0]        addr    = 4'h0;
	logic              rd      = 1'b0;
	logic              wr      = 1'b0;
	logic [31:0]       wdata   = 32'h0;
	logic              ce      = 1'b1;
	logic [3:0]        be      = 4'hf;
	logic [31:0]       rdata;
	logic [31:0]       d;
	logic              wait_r, wrst, wake, to_n, pd_n, rw_n, osc;
	wdtb_core_evt_type evt;
	int                miscompares = 0;
	int                compares    = 0;
	logic [4:0]        codes [5] = '{5'h00, 5'h01, 5'h02, 5'h13, 5'h1f};
	int                ks    [5] = '{5, 6, 7, 5, 5};
	int                srcs  [2] = '{3, 0};

	always #25 ref_clk = ~ref_clk;

	wdtb_core_model core (.ref_clk(ref_clk), .core_evt(evt), .low_freq_osc(osc));

	wdtb_watchdog dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .low_freq_osc(osc),
		.wdt_mode_cfg(mode), .core_evt(evt), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_byteenable(be), .avs_writedata(wdata),
		.avs_readdata(rdata), .avs_waitrequest(wait_r), .wdt_reset_req(wrst),
		.wake_req(wake), .timeout_flag_n(to_n), .powerdown_flag_n(pd_n),
		.wdt_reset_flag_n(rw_n));

	task automatic finish_test;
		$display("miscompares=%0d compares=%0d", miscompares, compares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk

	// one Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		addr  <= a;
		wr    <= w;
		rd    <= !w;
		wdata <= v;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(n < 20, "bus access never completed");
	endtask : bus

	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(d === e, "register read mismatch");
	endtask : rdc

	task automatic set_mode(input logic [1:0] m);
		@(posedge ref_clk);
		mode <= m;
	endtask : set_mode

	// no pulse of either kind for c cycles
	task automatic quiet(input int c);
		logic seen;
		seen = 1'b0;
		repeat (c) begin
			@(posedge ref_clk);
			if (wrst !== 1'b0 || wake !== 1'b0)
				seen = 1'b1;
		end
		chk(!seen, "unexpected time-out");
	endtask : quiet

	// time-out after 2^k ticks; w selects wake instead of reset
	task automatic expect_to(input int k, input logic w);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wrst !== 1'b1 && wake !== 1'b1 && n < (8 << k) + 40);
		chk(n > (8 << k) - 24 && n < (8 << k) + 40, "time-out at wrong moment");
		chk(wake === w && wrst === !w, "wrong kind of time-out");
	endtask : expect_to

	initial begin
		repeat (60000) @(posedge ref_clk);
		miscompares++;
		finish_test();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		rdc(CTRL_OFFSET, 32'h16);
		rdc(POWER_CONTROL_REG_OFFSET, 32'h10);
		rdc(STAT_OFFSET, 32'h18);
		rdc(4'hc, 32'h0);
		be <= 4'he;
		bus(1'b1, CTRL_OFFSET, 32'hff);
		be <= 4'hf;
		rdc(CTRL_OFFSET, 32'h16);
		bus(1'b1, CTRL_OFFSET, 32'hff);
		rdc(CTRL_OFFSET, 32'h3f);
		set_mode(2'h0);
		bus(1'b1, CTRL_OFFSET, 32'h01);
		core.send(3);
		quiet(600);
		set_mode(2'h1);
		core.send(3);
		expect_to(5, 1'b0);
		chk({to_n, rw_n} === 2'b00, "flags after reset time-out");
		core.send(4);
		rdc(CTRL_OFFSET, 32'h16);
		chk(rw_n === 1'b0, "reset flag lost");
		bus(1'b1, POWER_CONTROL_REG_OFFSET, 32'h10);
		rdc(POWER_CONTROL_REG_OFFSET, 32'h10);
		quiet(600);
		set_mode(2'h3);
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, CTRL_OFFSET, {26'h0, codes[i], 1'b0});
			core.send(3);
			expect_to(ks[i], 1'b0);
		end
		bus(1'b1, CTRL_OFFSET, 32'h2);
		core.send(3);
		ce <= 1'b0;
		quiet(600);
		ce <= 1'b1;
		expect_to(6, 1'b0);
		for (int i = 0; i < 2; i++) begin
			core.send(3);
			repeat (300) @(posedge ref_clk);
			core.send(srcs[i]);
			expect_to(6, 1'b0);
		end
		core.send(3);
		core.send(2);
		expect_to(6, 1'b1);
		chk({to_n, pd_n} === 2'b00, "flags after wake");
		set_mode(2'h2);
		core.send(2);
		quiet(700);
		core.send(1);
		expect_to(6, 1'b0);
		set_mode(2'h1);
		bus(1'b1, CTRL_OFFSET, 32'h3);
		core.send(2);
		expect_to(6, 1'b1);
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
